// ==== hw/shp_regs.svh ====
// Constants for the dual-mode serial host port: timing counts and fields.
// Assumes a 100 MHz system clock standing in for the crystal clock.
`ifndef SHP_REGS_SVH
`define SHP_REGS_SVH

// Word length in bits
`define SHP_WORD_BITS 8
// Internal SPI bit clock: half-period in system cycles (f/8, under f/4)
// Four cycles leave room for the two-stage MISO synchroniser.
`define SHP_SPI_HALF 4
// Internal I2C bit clock: quarter-period in system cycles (f/6 at most)
`define SHP_I2C_QTR 2
// Fixed bits of the own I2C slave address, placed round the address-pin bits
`define SHP_I2C_ADDR_HI 5'h0A
// Bit positions of the address pins inside the 7-bit address
`define SHP_ADDR_POS0 0
`define SHP_ADDR_POS2 2

`endif

// ==== hw/shp_pkg.sv ====
// Types shared by the serial host port.
// Assumes the constants header is included by the design module.
package shp_pkg;
	typedef enum logic [2:0] {
		SHP_IDLE,
		SHP_WAIT_REQ,
		SHP_START,
		SHP_BITS,
		SHP_ACK,
		SHP_STOP
	} shp_state_t;
endpackage

// ==== hw/shp_port.sv ====
// Dual-mode SPI/I2C serial host port, pin-level logic.
// Assumes pins are resolved by the bench from out/oe triples; pulls high.
`include "shp_regs.svh"
`timescale 1ns/1ns
`default_nettype none

// How it works
// - pins routed to SPI or I2C only
// - SPI clock output as master, input slave
// - master uses own divider, slave external
// - slave ignores clock without slave select
// - shift one edge, sample the other
// - SPI clock at most f/4, in f/3
// - I2C clock open-drain master, input slave
// - I2C clock at most f/6, in f/5
// - MISO input master, output slave, tristate
// - MOSI output master, input slave
// - SDA input receiving, open-drain transmitting
// - SDA changes only while SCL low
// - idle bus leaves SDA high
// - SDA fall with SCL high is start
// - SDA rise with SCL high is stop
// - address pin 0 forms slave address
// - address pin 2 forms slave address
// - master flags error on slave select
// - request line paces each word (SPI only; I2C ignores it)
module shp_port
	import shp_pkg::*;
#(
	parameter int WORD_BITS = `SHP_WORD_BITS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic mode_i2c,
	input wire logic mode_master,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [WORD_BITS-1:0] tx_data,
	output logic rx_valid,
	output logic [WORD_BITS-1:0] rx_data,
	output logic bus_error,
	output logic start_seen,
	output logic stop_seen,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic ss_b_in,
	input wire logic addr_pin0,
	input wire logic addr_pin2,
	input wire logic req_b_in,
	output logic req_b_out,
	output logic req_b_oe
);
	initial begin
		if (WORD_BITS < 8 || WORD_BITS > 32)
			$error("WORD_BITS out of range");
	end

	// two-stage synchronisers for every pin input
	logic [6:0] sync1_reg, sync2_reg, prev_reg;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sync1_reg <= 7'h7F;
			sync2_reg <= 7'h7F;
			prev_reg <= 7'h7F;
		end else begin
			sync1_reg <= {req_b_in, ss_b_in, mosi_in, miso_in, sck_in,
				addr_pin2, addr_pin0};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// Named views of the synchronised pins
	wire sck_s = sync2_reg[2];
	wire miso_s = sync2_reg[3];
	wire mosi_s = sync2_reg[4];
	wire ss_s = sync2_reg[5];
	wire req_s = sync2_reg[6];
	wire sck_rise = sck_s & ~prev_reg[2];
	wire sck_fall = ~sck_s & prev_reg[2];
	wire sda_rise = mosi_s & ~prev_reg[4];
	wire sda_fall = ~mosi_s & prev_reg[4];

	localparam logic [4:0] ADDR_HI = `SHP_I2C_ADDR_HI;
	wire [6:0] own_addr = {ADDR_HI[4:1], 1'b0, ADDR_HI[0], 1'b0} |
		((7'h01 << `SHP_ADDR_POS0) & {7{sync2_reg[0]}}) |
		((7'h01 << `SHP_ADDR_POS2) & {7{sync2_reg[1]}});

	// Bit-clock divider enable; one pulse per half SPI / quarter I2C bit
	localparam logic [3:0] SPI_HALF = 4'(`SHP_SPI_HALF);
	localparam logic [3:0] I2C_QTR = 4'(`SHP_I2C_QTR);
	logic [3:0] div_reg;
	wire [3:0] div_top = mode_i2c ? I2C_QTR : SPI_HALF;
	// half period of four cycles stays under f/4
	// four quarters of two cycles is f/8
	wire tick = (div_reg == div_top - 4'h1);
	always_ff @(posedge clk) begin
		if (!rst_b)
			div_reg <= 4'h0;
		else
			div_reg <= tick ? 4'h0 : div_reg + 4'h1;
	end

	// Transfer machine
	shp_state_t state_reg;
	logic [WORD_BITS-1:0] sh_reg;
	logic [5:0] cnt_reg;
	logic [1:0] ph_reg;
	logic clk_reg, dout_reg, sda_low_reg, scl_low_reg, active_reg;
	logic addr_phase_reg, addr_hit_reg;

	// Edges seen by the SPI slave, gated by slave select
	// ignore clock when not selected
	wire sel = ~ss_s;
	wire lead_edge = sel & (cpol ? sck_fall : sck_rise);
	wire trail_edge = sel & (cpol ? sck_rise : sck_fall);
	wire smp_edge = cpha ? trail_edge : lead_edge;
	wire shf_edge = cpha ? lead_edge : trail_edge;
	// I2C condition detection on synchronised SCL/SDA
	// start detection
	wire i2c_start = mode_i2c & sck_s & sda_fall;
	wire i2c_stop = mode_i2c & sck_s & sda_rise;
	wire last_bit = (cnt_reg == 6'(WORD_BITS - 1));
	// Word as the master holds it after its last sampling edge
	wire [WORD_BITS-1:0] m_word = cpha ?
		{sh_reg[WORD_BITS-2:0], miso_s} : sh_reg;

	assign tx_ready = (state_reg == SHP_IDLE) & ~active_reg;

	// SPI and I2C engines, master and slave
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= SHP_IDLE;
			sh_reg <= '0;
			cnt_reg <= 6'h00;
			ph_reg <= 2'h0;
			clk_reg <= 1'b0;
			dout_reg <= 1'b1;
			sda_low_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= '0;
			active_reg <= 1'b0;
			addr_phase_reg <= 1'b0;
			addr_hit_reg <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (mode_master) begin
				case (state_reg)
				SHP_IDLE: begin
					clk_reg <= cpol;
					if (tx_valid) begin
						sh_reg <= tx_data;
						cnt_reg <= 6'h00;
						ph_reg <= 2'h0;
						state_reg <= mode_i2c ? SHP_START : SHP_WAIT_REQ;
					end
				end
				SHP_WAIT_REQ: if (!req_s && tick) begin
					dout_reg <= sh_reg[WORD_BITS-1];
					state_reg <= SHP_BITS;
				end
				SHP_START: if (tick) begin
					// generate start, SDA falls while SCL high
					sda_low_reg <= 1'b1;
					ph_reg <= 2'h0;
					state_reg <= SHP_BITS;
				end
				SHP_BITS: if (tick) begin
					if (!mode_i2c) begin
						clk_reg <= ~clk_reg;
						ph_reg <= ph_reg + 2'h1;
						if (ph_reg[0] == cpha)
							sh_reg <= {sh_reg[WORD_BITS-2:0], miso_s};
						else
							dout_reg <= sh_reg[WORD_BITS-1];
						if (ph_reg[0]) begin
							cnt_reg <= cnt_reg + 6'h01;
							if (last_bit) begin
								rx_valid <= 1'b1;
								rx_data <= m_word;
								state_reg <= SHP_IDLE;
							end
						end
					end else begin
						ph_reg <= ph_reg + 2'h1;
						case (ph_reg)
						// data set only with SCL low
						2'h0: scl_low_reg <= 1'b1;
						2'h1: sda_low_reg <= ~sh_reg[WORD_BITS-1];
						2'h2: scl_low_reg <= 1'b0;
						default: begin
							sh_reg <= {sh_reg[WORD_BITS-2:0], 1'b1};
							cnt_reg <= cnt_reg + 6'h01;
							if (last_bit)
								state_reg <= SHP_ACK;
						end
						endcase
					end
				end
				SHP_ACK: if (tick) begin
					ph_reg <= ph_reg + 2'h1;
					case (ph_reg)
					2'h0: scl_low_reg <= 1'b1;
					2'h1: sda_low_reg <= 1'b0;
					2'h2: scl_low_reg <= 1'b0;
					default: state_reg <= SHP_STOP;
					endcase
				end
				SHP_STOP: if (tick) begin
					ph_reg <= ph_reg + 2'h1;
					case (ph_reg)
					2'h0: scl_low_reg <= 1'b1;
					2'h1: sda_low_reg <= 1'b1;
					2'h2: scl_low_reg <= 1'b0;
					default: begin
						sda_low_reg <= 1'b0;
						state_reg <= SHP_IDLE;
					end
					endcase
				end
				default: state_reg <= SHP_IDLE;
				endcase
			end else if (!mode_i2c) begin
				state_reg <= SHP_IDLE;
				if (!sel) begin
					active_reg <= 1'b0;
					cnt_reg <= 6'h00;
				end else if (smp_edge) begin
					active_reg <= 1'b1;
					sh_reg <= {sh_reg[WORD_BITS-2:0], mosi_s};
					cnt_reg <= cnt_reg + 6'h01;
					if (last_bit) begin
						rx_valid <= 1'b1;
						rx_data <= {sh_reg[WORD_BITS-2:0], mosi_s};
						cnt_reg <= 6'h00;
						active_reg <= 1'b0;
					end
				end else if (shf_edge)
					dout_reg <= sh_reg[WORD_BITS-1];
				else if (!active_reg && tx_valid)
					sh_reg <= tx_data;
			end else begin
				// I2C slave: address match and ACK
				state_reg <= SHP_IDLE;
				if (i2c_start) begin
					cnt_reg <= 6'h00;
					addr_phase_reg <= 1'b1;
					active_reg <= 1'b1;
					sda_low_reg <= 1'b0;
				end else if (i2c_stop) begin
					active_reg <= 1'b0;
					addr_phase_reg <= 1'b0;
					sda_low_reg <= 1'b0;
				end else if (active_reg && sck_rise) begin
					sh_reg <= {sh_reg[WORD_BITS-2:0], mosi_s};
					cnt_reg <= cnt_reg + 6'h01;
				end else if (active_reg && sck_fall) begin
					// ACK driven only after SCL falls
					if (cnt_reg == 6'h08) begin
						if (addr_phase_reg)
							addr_hit_reg <= (sh_reg[7:1] == own_addr);
						sda_low_reg <= addr_hit_reg |
							(addr_phase_reg & (sh_reg[7:1] == own_addr));
						if (!addr_phase_reg && addr_hit_reg) begin
							rx_valid <= 1'b1;
							rx_data <= sh_reg;
						end
					end else if (cnt_reg == 6'h09) begin
						sda_low_reg <= 1'b0;
						addr_phase_reg <= 1'b0;
						cnt_reg <= 6'h00;
					end
				end
			end
		end
	end

	// external slave select in SPI master mode
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bus_error <= 1'b0;
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
		end else begin
			bus_error <= (~mode_i2c & mode_master & ~ss_s) | bus_error;
			start_seen <= i2c_start;
			stop_seen <= i2c_stop;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			req_b_out <= 1'b1;
		else
			req_b_out <= ~(tx_valid & ~active_reg & ~smp_edge);
	end
	assign req_b_oe = ~mode_i2c & ~mode_master;

	assign sck_out = mode_i2c ? 1'b0 : clk_reg;
	assign sck_oe = mode_master & (mode_i2c ? scl_low_reg : 1'b1);
	assign miso_out = dout_reg;
	assign miso_oe = ~mode_i2c & ~mode_master & sel;
	// SDA open-drain on shared data pin
	assign mosi_out = mode_i2c ? 1'b0 : dout_reg;
	assign mosi_oe = mode_i2c ? sda_low_reg : mode_master;

	miso_tri_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!mode_i2c && !mode_master && ss_s) |-> !miso_oe)
		else $error("MISO driven while deselected");
	// no SDA pull in I2C master idle
	sda_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
		(mode_i2c && mode_master && state_reg == SHP_IDLE) |-> !mosi_oe)
		else $error("SDA pulled while idle");
	bus_err_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!mode_i2c && mode_master && !ss_s) |=> bus_error)
		else $error("bus error not flagged");
	mosi_dir_a: assert property (@(posedge clk) disable iff (!rst_b)
		!mode_i2c |-> (mosi_oe == mode_master))
		else $error("MOSI direction wrong");
	sck_dir_a: assert property (@(posedge clk) disable iff (!rst_b)
		!mode_i2c |-> (sck_oe == mode_master))
		else $error("SPI clock direction wrong");
	// SCL only pulled low, never by a slave
	scl_od_a: assert property (@(posedge clk) disable iff (!rst_b)
		mode_i2c |-> (!sck_out && (mode_master || !sck_oe)))
		else $error("SCL driven wrongly");
endmodule
`default_nettype wire

// ==== tb/shp_far_model.sv ====
// Far-side model: an SPI slave and an I2C slave facing the port.
// Assumes resolved pin levels from the bench, edges seen on clk.
`timescale 1ns/1ns
`default_nettype none
module shp_far_model (
	input wire logic clk,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic arm,
	input wire logic sck,
	input wire logic mosi,
	input wire logic scl,
	input wire logic sda,
	input wire logic [7:0] tx_word,
	output logic miso,
	output logic req_b,
	output logic sda_low,
	output logic [7:0] rx_word,
	output int starts,
	output int stops
);
	logic sck_q, scl_q, sda_q;
	int k, n, idx;

	// Idle state: no request, lines released
	initial begin
		{miso, sda_low, sck_q, rx_word} = 11'h0;
		{req_b, scl_q, sda_q} = 3'h7;
		{starts, stops, k, n} = {32'h0, 32'h0, 32'h9, 32'hA};
	end

	// Edge tracking and both slave behaviours
	always @(posedge clk) begin
		sck_q <= sck;
		scl_q <= scl;
		sda_q <= sda;
		if (arm) begin
			req_b <= 1'h0;
			k = 0;
		end else if (sck != sck_q) begin
			req_b <= 1'h1;
			if (sck == !(cpol ^ cpha))
				rx_word <= {rx_word[6:0], mosi};
			else
				k = k + 1;
		end
		idx = 7 - k + cpha;
		// Outside a frame the line keeps changing
		miso <= (idx >= 0 && idx < 8) ? tx_word[idx] : ~miso;
		if (scl && scl_q && sda_q && !sda) begin
			starts++;
			n = 0;
		end else if (scl && scl_q && !sda_q && sda) begin
			stops++;
			n = 10;
		end else if (scl && !scl_q && n < 8) begin
			rx_word <= {rx_word[6:0], sda};
			n = n + 1;
		end else if (!scl && scl_q && (n == 8 || n == 9)) begin
			sda_low <= (n == 8);
			n = n + 1;
		end
	end
endmodule
`default_nettype wire

// ==== tb/serial_host_spi_i2c_port_tb.sv ====
// Testbench for the serial host port: SPI master and slave, I2C master and slave.
// Assumes the far-side model file; pulls high on the I2C lines.
`timescale 1ns/1ns
`default_nettype none
module serial_host_spi_i2c_port_tb;
	logic clk = 0, rst_b = 0, mode_i2c = 0, mode_master = 1;
	logic cpol = 0, cpha = 0, tx_valid = 0, tb_sck = 0, tb_mosi = 0;
	logic ss_b = 1, pin0 = 0, pin2 = 0, arm = 0;
	logic [7:0] tx_data = 8'h00, far_tx = 8'h00, far_rx, rx_data;
	logic tx_ready, rx_valid, bus_error, sck_out, sck_oe, miso_out, miso_oe;
	logic mosi_out, mosi_oe, req_b_out, req_b_oe, far_miso, far_req_b;
	logic far_sda_low, start_seen, stop_seen;
	logic tb_scl_low = 0, tb_sda_low = 0;
	int fail_count = 0, n_checks = 0, rx_n = 0, dir_bad = 0, hx = 0;
	int cond_n = 0;
	int far_starts, far_stops;
	// Pin resolution from every party's enables
	wire scl_w = ~(mode_i2c & ((sck_oe & ~sck_out) | tb_scl_low));
	wire sda_w = ~(mode_i2c & ((mosi_oe & ~mosi_out) | far_sda_low |
		tb_sda_low));
	wire sck_w = mode_i2c ? scl_w : (sck_oe ? sck_out : tb_sck);
	wire mosi_w = mode_i2c ? sda_w : (mosi_oe ? mosi_out : tb_mosi);
	wire miso_w = miso_oe ? miso_out : far_miso;
	wire req_w = req_b_oe ? req_b_out : far_req_b;

	always #5 clk = ~clk;

	// Word count; pin direction misuse
	always @(posedge clk) begin
		rx_n <= rx_n + (rx_valid === 1'h1);
		cond_n <= cond_n + (start_seen === 1'h1) + (stop_seen === 1'h1);
		if (rst_b && ((mode_i2c || mode_master) && miso_oe !== 1'h0 ||
			mode_i2c && (sck_oe && sck_out !== 1'h0 ||
			mosi_oe && mosi_out !== 1'h0)))
			dir_bad <= dir_bad + 1;
	end

	shp_port i_shp_port (.clk(clk), .rst_b(rst_b), .mode_i2c(mode_i2c),
		.mode_master(mode_master), .cpol(cpol), .cpha(cpha),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.rx_valid(rx_valid), .rx_data(rx_data), .bus_error(bus_error),
		.start_seen(start_seen), .stop_seen(stop_seen), .sck_in(sck_w),
		.sck_out(sck_out), .sck_oe(sck_oe), .miso_in(miso_w),
		.miso_out(miso_out), .miso_oe(miso_oe), .mosi_in(mosi_w),
		.mosi_out(mosi_out), .mosi_oe(mosi_oe), .ss_b_in(ss_b),
		.addr_pin0(pin0), .addr_pin2(pin2), .req_b_in(req_w),
		.req_b_out(req_b_out), .req_b_oe(req_b_oe));

	shp_far_model i_far (.clk(clk), .cpol(cpol), .cpha(cpha), .arm(arm),
		.sck(sck_w & ~mode_i2c), .mosi(mosi_w), .scl(scl_w), .sda(sda_w),
		.tx_word(far_tx), .miso(far_miso), .req_b(far_req_b),
		.sda_low(far_sda_low), .rx_word(far_rx), .starts(far_starts),
		.stops(far_stops));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Half period of the 125 ns link clock on average
	task half;
		repeat (6 + (hx % 4 == 3)) @(posedge clk);
		hx++;
	endtask

	task restart(input logic i2c, input logic ms, input logic pol,
		input logic pha);
		@(posedge clk);
		rst_b <= 1'h0;
		{mode_i2c, mode_master, cpol, cpha} <= {i2c, ms, pol, pha};
		cyc(2);
		rst_b <= 1'h1;
		cyc(3);
	endtask

	// Master request held until taken with ready
	task send(input logic [7:0] w);
		int i;
		tx_data <= w;
		tx_valid <= 1'h1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (tx_ready !== 1'h1 && i < 50);
		tx_valid <= 1'h0;
	endtask

	task wait_rx(input int lim);
		int i, i0;
		i0 = rx_n;
		for (i = 0; i < lim && rx_n == i0; i++)
			@(posedge clk);
		cyc(2);
	endtask

	task t_master(input logic pol, input logic pha, input logic [7:0] mw,
		input logic [7:0] sw);
		int n0;
		restart(1'h0, 1'h1, pol, pha);
		far_tx <= sw;
		check(sck_oe, 1'h1);
		check(mosi_oe, 1'h1);
		check(sck_out, pol);
		n0 = rx_n;
		send(mw);
		cyc(10);
		check(sck_out, pol);
		check(rx_n, n0);
		arm <= 1'h1;
		@(posedge clk);
		arm <= 1'h0;
		wait_rx(400);
		check(rx_data, sw);
		check(far_rx, mw);
		$display("spi master mode %0d%0d done", pol, pha);
	endtask

	task t_buserr;
		check(bus_error, 1'h0);
		ss_b <= 1'h0;
		cyc(2);
		ss_b <= 1'h1;
		cyc(6);
		check(bus_error, 1'h1);
		$display("bus error done");
	endtask

	task spi_word(input logic [7:0] w);
		int i;
		for (i = 0; i < 8; i++) begin
			tb_mosi <= w[7 - i];
			half();
			tb_sck <= 1'h1;
			half();
			tb_sck <= 1'h0;
		end
		half();
		tb_mosi <= ~tb_mosi;
	endtask

	task t_slave;
		int n0;
		restart(1'h0, 1'h0, 1'h0, 1'h0);
		check(sck_oe, 1'h0);
		check(mosi_oe, 1'h0);
		check(miso_oe, 1'h0);
		n0 = rx_n;
		spi_word(8'h3C);
		cyc(4);
		check(rx_n, n0);
		ss_b <= 1'h0;
		tx_data <= 8'h96;
		tx_valid <= 1'h1;
		cyc(4);
		check(miso_oe, 1'h1);
		check(req_b_oe, 1'h1);
		check(req_b_out, 1'h0);
		spi_word(8'hC3);
		tx_valid <= 1'h0;
		cyc(4);
		check(rx_n, n0 + 1);
		check(rx_data, 8'hC3);
		ss_b <= 1'h1;
		cyc(4);
		check(miso_oe, 1'h0);
		$display("spi slave done");
	endtask

	task t_i2c;
		int i, c0;
		restart(1'h1, 1'h1, 1'h0, 1'h0);
		c0 = cond_n;
		check(scl_w, 1'h1);
		check(sda_w, 1'h1);
		{pin0, pin2} <= 2'h3;
		send(8'h96);
		for (i = 0; i < 800 && far_stops == 0; i++)
			@(posedge clk);
		cyc(4);
		check(far_starts, 1);
		check(far_stops, 1);
		check(far_rx, 8'h96);
		check(dir_bad, 0);
		check(sda_w, 1'h1);
		check(cond_n - c0, 2);
		$display("i2c master done");
	endtask

	// Bench as I2C master: one bit, SDA set while SCL is low
	task i2c_bit(input logic b);
		tb_sda_low <= ~b;
		cyc(4);
		tb_scl_low <= 1'h0;
		cyc(4);
		tb_scl_low <= 1'h1;
		cyc(2);
	endtask

	// Eight bits, then the acknowledge slot; got is the port's pull
	task i2c_byte(input logic [7:0] w, output logic got);
		int i;
		for (i = 0; i < 8; i++)
			i2c_bit(w[7 - i]);
		tb_sda_low <= 1'h0;
		cyc(4);
		got = mosi_oe;
		tb_scl_low <= 1'h0;
		cyc(4);
		tb_scl_low <= 1'h1;
		cyc(2);
	endtask

	task i2c_start;
		tb_sda_low <= 1'h1;
		cyc(4);
		tb_scl_low <= 1'h1;
		cyc(2);
	endtask

	task i2c_stop;
		tb_sda_low <= 1'h1;
		cyc(2);
		tb_scl_low <= 1'h0;
		cyc(4);
		tb_sda_low <= 1'h0;
		cyc(6);
	endtask

	// Own address with both pins high: 0x0A spread round bits 0 and 2
	task t_i2c_slave;
		logic got;
		int c0;
		{pin0, pin2} <= 2'h3;
		restart(1'h1, 1'h0, 1'h0, 1'h0);
		check(sck_oe, 1'h0);
		c0 = cond_n;
		i2c_start();
		i2c_byte(8'h52, got);
		check(got, 1'h0);
		i2c_stop();
		i2c_start();
		i2c_byte(8'h58, got);
		check(got, 1'h0);
		i2c_stop();
		i2c_start();
		i2c_byte(8'h5A, got);
		check(got, 1'h1);
		i2c_byte(8'hB7, got);
		check(got, 1'h1);
		i2c_stop();
		check(rx_data, 8'hB7);
		check(cond_n - c0, 6);
		$display("i2c slave done");
	endtask

	// Main sequence over all four SPI formats, then the rest
	initial begin
		t_master(1'h0, 1'h0, 8'hA5, 8'h5A);
		t_master(1'h0, 1'h1, 8'h81, 8'h7E);
		t_master(1'h1, 1'h0, 8'h3C, 8'hC4);
		t_master(1'h1, 1'h1, 8'hF0, 8'h0F);
		t_buserr();
		t_slave();
		t_i2c();
		t_i2c_slave();
		stop_test();
	end

	// Watchdog well past the expected run length
	initial begin
		#200000;
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire
